/* hdl/iir_pkg.sv */
// Constants, register map and helper functions of the internal event interrupt router
package iir_pkg;

    // ------------------------------------------------------------------
    // Source positions in status, clear, enable and route registers
    // ------------------------------------------------------------------
    localparam int unsigned NSRC             = 13;
    localparam int unsigned SRC_PCI_ERRLOG   = 0;
    localparam int unsigned SRC_PARITY       = 1;
    localparam int unsigned SRC_LOCAL_ERRLOG = 2;
    localparam int unsigned SRC_DMA_LBUS     = 3;
    localparam int unsigned SRC_DMA_PCI      = 4;
    localparam int unsigned SRC_DMA_RESET    = 5;
    localparam int unsigned SRC_DMA_FINISH   = 6;
    localparam int unsigned SRC_CFG_STATUS   = 7;
    localparam int unsigned SRC_MAILBOX0     = 8;
    localparam int unsigned NMBX             = 4;
    localparam int unsigned SRC_LBUS_PARITY  = 12;

    // ------------------------------------------------------------------
    // DMA control and status flag positions
    // ------------------------------------------------------------------
    localparam int unsigned DMA_W        = 4;
    localparam int unsigned DMA_LBUS_ERR = 0;
    localparam int unsigned DMA_PCI_ERR  = 1;
    localparam int unsigned DMA_RESET    = 2;
    localparam int unsigned DMA_DONE     = 3;
    localparam int unsigned CFG_W        = 5;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W    = 12;
    localparam logic [11:0] OFF_STAT  = 12'h000;
    localparam logic [11:0] OFF_CLEAR = 12'h004;
    localparam logic [11:0] OFF_EN    = 12'h008;
    localparam logic [11:0] OFF_ROUTE = 12'h00c;
    localparam logic [11:0] OFF_DMA   = 12'h010;
    localparam logic [11:0] OFF_RAW   = 12'h014;

    // ------------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [NSRC-1:0]  EN_RST    = 13'h0000;
    localparam logic [NSRC-1:0]  ROUTE_RST = 13'h0000;
    localparam logic [NSRC-1:0]  STAT_RST  = 13'h0000;
    localparam logic [DMA_W-1:0] DMA_RST   = 4'h0;
    localparam logic             ROUTE_PCI = 1'b1;

    // Sticky update: a set in the same cycle as its clear wins
    function automatic logic [NSRC-1:0] sticky(input logic [NSRC-1:0] cur,
                                               input logic [NSRC-1:0] set,
                                               input logic [NSRC-1:0] clr);
        sticky = (cur & ~clr) | set;
    endfunction : sticky

endpackage : iir_pkg

/* hdl/iir_router.sv */
// Internal event interrupt router with APB register slave
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module iir_router
(
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [iir_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Level source flags from the bridge
    input  wire logic                       pci_error_logged,
    input  wire logic                       master_parity_detected,
    input  wire logic                       local_error_logged,
    input  wire logic [iir_pkg::CFG_W-1:0]  cfg_status_bits,
    // DMA event pulses
    input  wire logic                       dma_local_bus_err,
    input  wire logic                       dma_pci_err,
    input  wire logic                       dma_reset_evt,
    input  wire logic                       dma_done_evt,
    // Mailbox write pulses, one per mailbox
    input  wire logic [iir_pkg::NMBX-1:0]   mbx_wr_from_pci,
    input  wire logic [iir_pkg::NMBX-1:0]   mbx_wr_from_lbus,
    // Local-bus data parity error pulse
    input  wire logic                       lbus_parity_err,
    // PCI interrupt pin, open drain
    input  wire logic                       pci_irq_n_i,
    output logic                            pci_irq_n_o,
    output logic                            pci_irq_n_oe_n,
    // Local-bus interrupt pin, open drain
    input  wire logic                       local_bus_irq_n_i,
    output logic                            local_bus_irq_n_o,
    output logic                            local_bus_irq_n_oe_n,
    // Summary interrupt
    output logic                            irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    iir_stat_if sb ();

    logic [iir_pkg::NSRC-1:0]  irq_enable_reg_q;
    logic [iir_pkg::NSRC-1:0]  irq_route_reg_q;
    logic [iir_pkg::DMA_W-1:0] dma_ctrl_status_reg_q;
    logic [iir_pkg::DMA_W-1:0] dma_evt;
    logic [iir_pkg::DMA_W-1:0] dma_clr;
    logic [31:0]               prdata_q;
    logic [31:0]               rd_word;
    logic [iir_pkg::NSRC-1:0]  src_level;
    logic [iir_pkg::NMBX-1:0]  mbx_set;
    logic                      setup_rd;
    logic                      acc;
    logic                      wr;
    logic                      mapped;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Registers never stall, so every access phase completes at once
    assign acc      = psel && penable;
    assign wr       = acc && pwrite;
    assign setup_rd = psel && !penable && !pwrite;
    assign mapped   = (paddr == iir_pkg::OFF_STAT)  || (paddr == iir_pkg::OFF_CLEAR) ||
                      (paddr == iir_pkg::OFF_EN)    || (paddr == iir_pkg::OFF_ROUTE) ||
                      (paddr == iir_pkg::OFF_DMA)   || (paddr == iir_pkg::OFF_RAW);
    assign pready   = 1'b1;
    assign pslverr  = acc && !mapped;

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // enable register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_enable_reg_q <= iir_pkg::EN_RST;
        else if (wr && paddr == iir_pkg::OFF_EN)
            irq_enable_reg_q <= pwdata[iir_pkg::NSRC-1:0];
    end

    // route register, bit high selects the PCI pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_route_reg_q <= iir_pkg::ROUTE_RST;
        else if (wr && paddr == iir_pkg::OFF_ROUTE)
            irq_route_reg_q <= pwdata[iir_pkg::NSRC-1:0];
    end

    // ------------------------------------------------------------------
    // DMA control and status flags
    // ------------------------------------------------------------------
    assign dma_evt[iir_pkg::DMA_LBUS_ERR] = dma_local_bus_err;
    assign dma_evt[iir_pkg::DMA_PCI_ERR]  = dma_pci_err;
    assign dma_evt[iir_pkg::DMA_RESET]    = dma_reset_evt;
    assign dma_evt[iir_pkg::DMA_DONE]     = dma_done_evt;
    assign dma_clr = (wr && paddr == iir_pkg::OFF_DMA) ? pwdata[iir_pkg::DMA_W-1:0]
                                                         : iir_pkg::DMA_RST;

    // flags clear on write one, a new event wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dma_ctrl_status_reg_q <= iir_pkg::DMA_RST;
        else
            dma_ctrl_status_reg_q <= (dma_ctrl_status_reg_q & ~dma_clr) | dma_evt;
    end

    // ------------------------------------------------------------------
    // Source collection
    // ------------------------------------------------------------------
    // mailbox set only from the far side of its route
    always_comb
    begin
        for (int i = 0; i < iir_pkg::NMBX; i++)
        begin
            if (irq_route_reg_q[iir_pkg::SRC_MAILBOX0 + i] == iir_pkg::ROUTE_PCI)
                mbx_set[i] = mbx_wr_from_lbus[i];
            else
                mbx_set[i] = mbx_wr_from_pci[i];
        end
    end

    assign src_level[iir_pkg::SRC_PCI_ERRLOG]   = pci_error_logged;
    assign src_level[iir_pkg::SRC_PARITY]       = master_parity_detected;
    assign src_level[iir_pkg::SRC_LOCAL_ERRLOG] = local_error_logged;
    assign src_level[iir_pkg::SRC_DMA_LBUS]     = dma_ctrl_status_reg_q[iir_pkg::DMA_LBUS_ERR];
    assign src_level[iir_pkg::SRC_DMA_PCI]      = dma_ctrl_status_reg_q[iir_pkg::DMA_PCI_ERR];
    assign src_level[iir_pkg::SRC_DMA_RESET]    = dma_ctrl_status_reg_q[iir_pkg::DMA_RESET];
    assign src_level[iir_pkg::SRC_DMA_FINISH]   = dma_ctrl_status_reg_q[iir_pkg::DMA_DONE];
    assign src_level[iir_pkg::SRC_CFG_STATUS]   = |cfg_status_bits;
    assign src_level[iir_pkg::SRC_MAILBOX0 +: iir_pkg::NMBX] = mbx_set;
    assign src_level[iir_pkg::SRC_LBUS_PARITY]  = lbus_parity_err;

    // a source still high keeps setting, so an early clear is lost
    assign sb.set   = src_level & irq_enable_reg_q;
    // write one to the clear register
    assign sb.clr   = (wr && paddr == iir_pkg::OFF_CLEAR) ? pwdata[iir_pkg::NSRC-1:0]
                                                            : iir_pkg::STAT_RST;
    assign sb.en    = irq_enable_reg_q;
    assign sb.route = irq_route_reg_q;

    iir_stat_bank u_bank
    (
        .pclk    (pclk),
        .presetn (presetn),
        .sb      (sb.bank)
    );

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // status readable, write-only clear reads zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (paddr)
            iir_pkg::OFF_STAT:  rd_word[iir_pkg::NSRC-1:0]  = sb.stat;
            iir_pkg::OFF_EN:    rd_word[iir_pkg::NSRC-1:0]  = irq_enable_reg_q;
            iir_pkg::OFF_ROUTE: rd_word[iir_pkg::NSRC-1:0]  = irq_route_reg_q;
            iir_pkg::OFF_DMA:   rd_word[iir_pkg::DMA_W-1:0] = dma_ctrl_status_reg_q;
            iir_pkg::OFF_RAW:
            begin
                rd_word[iir_pkg::NSRC-1:0] = src_level;
                rd_word[iir_pkg::NSRC]     = pci_irq_n_i;
                rd_word[iir_pkg::NSRC + 1] = local_bus_irq_n_i;
            end
            default:            rd_word = 32'h0000_0000;
        endcase
    end

    // Read data captured in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (setup_rd)
            prdata_q <= rd_word;
    end

    assign prdata = prdata_q;

    // ------------------------------------------------------------------
    // Interrupt pins
    // ------------------------------------------------------------------
    // open drain: drive low, release otherwise
    assign pci_irq_n_o          = 1'b0;
    assign pci_irq_n_oe_n       = !sb.pci_req;
    assign local_bus_irq_n_o    = 1'b0;
    assign local_bus_irq_n_oe_n = !sb.lbus_req;
    // Summary level for the local interrupt tree
    assign irq                  = sb.pci_req || sb.lbus_req;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_stat_setup;
        psel && !penable && !pwrite && paddr == iir_pkg::OFF_STAT;
    endsequence

    // One cycle of an enabled parity source; two in a row mean the source is still held
    sequence s_parity_src;
        master_parity_detected && irq_enable_reg_q[iir_pkg::SRC_PARITY];
    endsequence

    sequence s_dma_reset_clear;
        wr && paddr == iir_pkg::OFF_DMA && pwdata[iir_pkg::DMA_RESET] && !dma_reset_evt;
    endsequence

    AST_DISABLED_QUIET: assert property (
        (irq_enable_reg_q == 0) |-> (pci_irq_n_oe_n && local_bus_irq_n_oe_n && !irq))
        else $error("Pin driven with all sources disabled");

    AST_ROUTE_PCI: assert property (
        ((sb.stat & irq_enable_reg_q & irq_route_reg_q) != 0) |-> !pci_irq_n_oe_n)
        else $error("PCI-routed status not on PCI pin");

    AST_ROUTE_LBUS: assert property (
        ((sb.stat & irq_enable_reg_q & ~irq_route_reg_q) == 0) |-> local_bus_irq_n_oe_n)
        else $error("Local pin driven without a routed status");

    AST_STAT_READ: assert property (
        s_stat_setup ##1 acc |-> prdata[iir_pkg::NSRC-1:0] == $past(sb.stat))
        else $error("Status read data wrong");

    AST_CLEAR_HELD: assert property (
        s_parity_src ##1 s_parity_src
        |-> sb.stat[iir_pkg::SRC_PARITY] ##1 sb.stat[iir_pkg::SRC_PARITY])
        else $error("Status dropped while source held");

    AST_DMA_RESET_CLR: assert property (
        s_dma_reset_clear |=> !dma_ctrl_status_reg_q[iir_pkg::DMA_RESET])
        else $error("DMA reset flag not cleared by write one");

    AST_ERRLOG_SET: assert property (
        (pci_error_logged && irq_enable_reg_q[iir_pkg::SRC_PCI_ERRLOG])
        |=> sb.stat[iir_pkg::SRC_PCI_ERRLOG])
        else $error("PCI error log status not set");

    AST_DMA_DONE_SET: assert property (
        dma_done_evt |=> dma_ctrl_status_reg_q[iir_pkg::DMA_DONE]
        and (!irq_enable_reg_q[iir_pkg::SRC_DMA_FINISH] or ##1 sb.stat[iir_pkg::SRC_DMA_FINISH]))
        else $error("DMA done flag or status missing");

    AST_CFG_SET: assert property (
        (cfg_status_bits != 0 && irq_enable_reg_q[iir_pkg::SRC_CFG_STATUS])
        |=> sb.stat[iir_pkg::SRC_CFG_STATUS])
        else $error("Configuration status interrupt not set");

    AST_MBX_SAME_SIDE: assert property (
        (irq_route_reg_q[iir_pkg::SRC_MAILBOX0] != iir_pkg::ROUTE_PCI && !mbx_wr_from_pci[0]
         && !sb.stat[iir_pkg::SRC_MAILBOX0]) |=> !sb.stat[iir_pkg::SRC_MAILBOX0])
        else $error("Mailbox set by a same-side write");

    AST_LBUS_PARITY: assert property (
        (lbus_parity_err && !irq_enable_reg_q[iir_pkg::SRC_LBUS_PARITY]
         && !sb.stat[iir_pkg::SRC_LBUS_PARITY]) |=> !sb.stat[iir_pkg::SRC_LBUS_PARITY])
        else $error("Disabled parity error set its status");

endmodule : iir_router

/* hdl/iir_stat_bank.sv */
// Sticky interrupt status bits and per-pin request merge
`timescale 1ns/10ps
module iir_stat_bank
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Register side
    iir_stat_if.bank  sb
);

    logic [iir_pkg::NSRC-1:0] stat_q;

    // ------------------------------------------------------------------
    // Status storage
    // ------------------------------------------------------------------
    // write one clears
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stat_q <= iir_pkg::STAT_RST;
        else
            stat_q <= iir_pkg::sticky(stat_q, sb.set, sb.clr);
    end

    assign sb.stat = stat_q;

    assign sb.pci_req  = |(stat_q & sb.en & sb.route);
    assign sb.lbus_req = |(stat_q & sb.en & ~sb.route);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_ZERO_KEEPS: assert property (
        ##1 ((stat_q & ~$past(sb.clr)) & $past(stat_q)) == ($past(stat_q) & ~$past(sb.clr)))
        else $error("Status bit lost without a clear");

    AST_SET_WINS: assert property (
        (sb.set != 0) |=> ((stat_q & $past(sb.set)) == $past(sb.set)))
        else $error("Status set lost against clear");

    AST_CLEAR_TAKES: assert property (
        (sb.clr != 0 && sb.set == 0) |=> ((stat_q & $past(sb.clr)) == 0))
        else $error("Status not cleared by write one");

endmodule : iir_stat_bank

/* hdl/iir_stat_if.sv */
// Status bank connection between the register logic and the status bank
`timescale 1ns/10ps
interface iir_stat_if;
    logic [iir_pkg::NSRC-1:0] set;
    logic [iir_pkg::NSRC-1:0] clr;
    logic [iir_pkg::NSRC-1:0] en;
    logic [iir_pkg::NSRC-1:0] route;
    logic [iir_pkg::NSRC-1:0] stat;
    logic                     pci_req;
    logic                     lbus_req;

    modport regs (output set, clr, en, route, input stat, pci_req, lbus_req);
    modport bank (input set, clr, en, route, output stat, pci_req, lbus_req);
endinterface : iir_stat_if

/* test/iir_pin_model.sv */
// Open-drain wires of the two interrupt pins with their pull-ups
`timescale 1ns/10ps
module iir_pin_model
(
    // Driver side of the router
    input  wire logic pci_o,
    input  wire logic pci_oe_n,
    input  wire logic lbus_o,
    input  wire logic lbus_oe_n,
    // Resolved wire levels
    output logic      pci_pin,
    output logic      lbus_pin
);
    // pull-up wires
    // A released wire rises to the pull-up level, it never keeps the last driven value
    assign pci_pin  = pci_oe_n ? 1'b1 : pci_o;
    assign lbus_pin = lbus_oe_n ? 1'b1 : lbus_o;
endmodule : iir_pin_model

/* test/test_internal_event_interrupt_router.sv */
// Self-checking bench for the internal event interrupt router
`timescale 1ns/10ps
module test_internal_event_interrupt_router;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pel, mpd, lel, dle, dpe, dre, dde, lpe;
    logic [4:0]  cfg;
    logic [3:0]  mb_pci, mb_lb;
    logic        po, poe_n, lo, loe_n, pci_pin, lbus_pin;
    int          miscompares = 0;
    int          n_checks = 0;

    // ------------------------------------------------------------------
    // Design and pin wires
    // ------------------------------------------------------------------
    iir_router u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pci_error_logged(pel),
        .master_parity_detected(mpd), .local_error_logged(lel), .cfg_status_bits(cfg),
        .dma_local_bus_err(dle), .dma_pci_err(dpe), .dma_reset_evt(dre),
        .dma_done_evt(dde), .mbx_wr_from_pci(mb_pci), .mbx_wr_from_lbus(mb_lb),
        .lbus_parity_err(lpe), .pci_irq_n_i(pci_pin), .pci_irq_n_o(po),
        .pci_irq_n_oe_n(poe_n), .local_bus_irq_n_i(lbus_pin), .local_bus_irq_n_o(lo),
        .local_bus_irq_n_oe_n(loe_n), .irq(irq));
    iir_pin_model u_pins (.pci_o(po), .pci_oe_n(poe_n), .lbus_o(lo),
        .lbus_oe_n(loe_n), .pci_pin(pci_pin), .lbus_pin(lbus_pin));

    // Free-running bus clock, 50 ns period
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // One APB transfer; the request stands until pready is seen high
    task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp, what);
    endtask : rd_chk

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask : step

    // Drive source k; cfg status uses one of its five flag bits
    task automatic drive(input int k, input logic v);
        case (k)
            0: pel <= v;
            1: mpd <= v;
            2: lel <= v;
            3: dle <= v;
            4: dpe <= v;
            5: dre <= v;
            6: dde <= v;
            7: cfg <= v ? 5'h04 : 5'h00;
            default: lpe <= v;
        endcase
    endtask : drive

    // Level sources stay high, event sources give a one-cycle pulse
    task automatic fire(input int k, input logic lvl);
        drive(k, 1'b1);
        step(1);
        if (!lvl)
            drive(k, 1'b0);
        step(3);
    endtask : fire

    task automatic mpulse(input int i, input logic from_pci);
        if (from_pci)
            mb_pci <= 4'h1 << i;
        else
            mb_lb <= 4'h1 << i;
        step(1);
        mb_pci <= 4'h0;
        mb_lb  <= 4'h0;
        step(2);
    endtask : mpulse

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        rd_chk(iir_pkg::OFF_STAT, 32'h0, "status after reset");
        rd_chk(iir_pkg::OFF_DMA, 32'h0, "dma flags after reset");
        chk(32'({pci_pin, lbus_pin, irq}), 32'h6, "pins after reset");
        rd_chk(iir_pkg::OFF_RAW, 32'h6000, "pin readback idle");
        wr(iir_pkg::OFF_EN, 32'hffff_ffff);
        rd_chk(iir_pkg::OFF_EN, 32'h1fff, "enable readback");
        wr(iir_pkg::OFF_EN, 32'h0);
        wr(iir_pkg::OFF_STAT, 32'h1fff);
        rd_chk(iir_pkg::OFF_STAT, 32'h0, "status is read-only");
        rd_chk(iir_pkg::OFF_CLEAR, 32'h0, "clear reads zero");
        apb(1'b0, 12'h100, 32'h0, r, e);
        chk(32'(e), 32'h1, "unmapped error");
    endtask : t_regs

    // Every non-mailbox source: gating, steering, sticky clear order
    task automatic t_sources();
        int          ks[9] = '{0, 1, 2, 3, 4, 5, 6, 7, 12};
        int          k;
        logic        lvl;
        logic        rt;
        logic [31:0] m;
        logic [31:0] x;
        foreach (ks[i])
        begin
            k   = ks[i];
            lvl = (k <= 2) || (k == 7);
            m   = 32'h1 << k;
            rt  = (i % 2) == 1;
            wr(iir_pkg::OFF_EN, 32'h0);
            fire(k, lvl);
            rd_chk(iir_pkg::OFF_STAT, 32'h0, "disabled source");
            wr(iir_pkg::OFF_EN, m);
            wr(iir_pkg::OFF_ROUTE, rt ? m : 32'h0);
            fire(k, lvl);
            rd_chk(iir_pkg::OFF_STAT, m, "status set");
            chk(32'({pci_pin, lbus_pin, irq}), 32'({~rt, rt, 1'b1}), "routed pin");
            // Pulse parity source is gone by now; bit 13 reads the PCI wire, bit 14 the local
            x = ((k == 12) ? 32'h0 : m) | (rt ? 32'h4000 : 32'h2000);
            rd_chk(iir_pkg::OFF_RAW, x, "pin readback");
            if (k >= 3 && k <= 6)
                rd_chk(iir_pkg::OFF_DMA, 32'h1 << (k - 3), "dma flag");
            wr(iir_pkg::OFF_CLEAR, 32'h0);
            rd_chk(iir_pkg::OFF_STAT, m, "clear with zero");
            wr(iir_pkg::OFF_CLEAR, m);
            rd_chk(iir_pkg::OFF_STAT, (k == 12) ? 32'h0 : m, "early clear");
            if (lvl)
                drive(k, 1'b0);
            if (k >= 3 && k <= 6)
            begin
                wr(iir_pkg::OFF_DMA, 32'h1 << (k - 3));
                rd_chk(iir_pkg::OFF_DMA, 32'h0, "dma flag cleared");
            end
            step(2);
            wr(iir_pkg::OFF_CLEAR, m);
            rd_chk(iir_pkg::OFF_STAT, 32'h0, "late clear");
            chk(32'({pci_pin, lbus_pin, irq}), 32'h6, "pins released");
        end
    endtask : t_sources

    // Mailboxes raise status only when written from the far bus
    task automatic t_mailbox();
        logic [31:0] m;
        for (int i = 0; i < 4; i++)
        begin
            for (int r = 0; r < 2; r++)
            begin
                m = 32'h100 << i;
                wr(iir_pkg::OFF_EN, m);
                wr(iir_pkg::OFF_ROUTE, (r == 1) ? m : 32'h0);
                mpulse(i, r == 1);
                rd_chk(iir_pkg::OFF_STAT, 32'h0, "mailbox same side");
                mpulse(i, r == 0);
                rd_chk(iir_pkg::OFF_STAT, m, "mailbox far side");
                chk(32'(pci_pin), 32'(r == 0), "mailbox pin");
                wr(iir_pkg::OFF_CLEAR, m);
            end
        end
    endtask : t_mailbox

    task automatic tally_and_finish();
        $display("checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // Main sequence: reset for ten cycles, then the scenarios
    initial
    begin
        {presetn, psel, penable, pwrite, pel, mpd, lel, dle, dpe, dre, dde, lpe} = '0;
        paddr  = 12'h000;
        pwdata = 32'h0;
        cfg    = 5'h00;
        mb_pci = 4'h0;
        mb_lb  = 4'h0;
        step(10);
        presetn <= 1'b1;
        t_regs();
        t_sources();
        t_mailbox();
        tally_and_finish();
    end

    // Watchdog, well beyond the few hundred cycles the scenarios need
    initial
    begin
        step(20000);
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule : test_internal_event_interrupt_router
